// >>> src/sgm_map.svh
// Register map, bit positions, reset values and input indices of the signal modulator.
// Assumes byte addressing on APB with 32-bit data, one register per aligned word.
//
// Contract
// RULE1: Output is selected carrier AND modulator; the code passes the selected carrier through with no AND against the modulator.
// RULE2: Modulator high mixes high carrier, low mixes low.
// RULE3: Disabled: carriers grounded, modulator from software bit.
// RULE4: Pin enable cleared holds pin low, mixing continues.
// RULE5: Synced carrier pulse falls before switching carriers.
// RULE6: High carrier sync only by its own bit.
// RULE7: Low carrier sync only by its own bit.
// RULE8: High carrier invert bit inverts high carrier.
// RULE9: Low carrier invert bit inverts low carrier.
// RULE10: Carrier pin disable removes source's pin drive.
// RULE11: Modulator pin disable removes source's pin drive.
// RULE12: Output invert bit inverts pin output.
// RULE13: Slew limit bit drives slew control, resets one.
// RULE14: Keeps running in sleep when inputs run.
// RULE15: Reset disables module and restores register defaults.
// RULE16: Enable bit 7 mixes; cleared gives no output.
// RULE17: Pin output enable bit 6 gates pin.
// RULE18: Read-only bit 3 shows modulator output.
// RULE19: Bit 0 is modulator only for source 0000.
// RULE20: Modulator selector decodes pin, PWMs, comparators, serials.
// RULE21: Modulator codes 1011 to 1111 connect nothing.
// RULE22: Unimplemented control and source bits read zero.
// RULE23: Each carrier has own 4-bit source selector.
`ifndef SGM_MAP_SVH
`define SGM_MAP_SVH

`define SGM_ADDR_CTRL      12'h000
`define SGM_ADDR_SRC       12'h004
`define SGM_ADDR_HIGH_CARRIER      12'h008
`define SGM_ADDR_LOW_CARRIER      12'h00C

`define SGM_BIT_EN         7
`define SGM_BIT_OE         6
`define SGM_BIT_SLEW       5
`define SGM_BIT_OINV       4
`define SGM_BIT_STAT       3
`define SGM_BIT_SWBIT      0
`define SGM_BIT_ODIS       7
`define SGM_BIT_POL        6
`define SGM_BIT_SYNC       5

`define SGM_RST_CTRL       8'h20
`define SGM_RST_SRC        8'h00
`define SGM_RST_CAR        8'h00
`define SGM_WMASK_CTRL     8'hF1
`define SGM_WMASK_SRC      8'h8F
`define SGM_WMASK_CAR      8'hEF

`define SGM_NUM_IN         13
`define SGM_NUM_PINDIS     9
`define SGM_IN_MODPIN      0
`define SGM_IN_CCP         4
`define SGM_IN_COMP        8
`define SGM_IN_SER         10
`define SGM_IN_UART        12

`endif

// >>> src/sgm_pkg.sv
// Types shared by the signal modulator design.
// Assumes the constants header is included by the modules that need numbers.
package sgm_pkg;

   // Carrier currently mixed into the output.
   typedef enum logic {
      SGM_ON_LOW,
      SGM_ON_HIGH
   } sgm_state_t;

   // Four-bit source selector code.
   typedef logic [3:0] sgm_sel_t;

endpackage

// >>> src/sgm_modulator.sv
// Signal modulator: APB register file, source selection, carrier sync and output pin.
// Assumes all source inputs come from pins or other clock domains and are synchronised here.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
`include "sgm_map.svh"

module sgm_modulator
   import sgm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        modulator_input_pin,
   input  wire logic        carrier_input_pin_a,
   input  wire logic        carrier_input_pin_b,
   input  wire logic        ref_clock_signal,
   input  wire logic [3:0]  capture_pwm_out,
   input  wire logic [1:0]  comparator_out,
   input  wire logic [1:0]  serial_data_out,
   input  wire logic        uart_tx_out,
   output logic             modulated_output,
   output logic             slew_limit_enable,
   output logic [8:0]       source_pin_disable
);

   // Raw and synchronised source inputs.
   logic [`SGM_NUM_IN-1:0] in_raw;
   logic [`SGM_NUM_IN-1:0] in_meta;
   logic [`SGM_NUM_IN-1:0] in_sync;

   // Register state.
   logic [7:0] modulation_control;
   logic [7:0] modulation_source_select;
   logic [7:0] high_carrier_control;
   logic [7:0] low_carrier_control;
   logic [7:0] next_modulation_control;
   logic [7:0] next_modulation_source_select;
   logic [7:0] next_high_carrier_control;
   logic [7:0] next_low_carrier_control;

   // Bus answer state.
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        wr_fire;
   logic        setup;
   logic        mapped;
   logic [7:0]  read_value;

   // Mixing state.
   sgm_state_t state;
   sgm_state_t next_state;
   logic       module_enable;
   logic       high_carrier;
   logic       low_carrier;
   logic       mod_signal;
   logic       mixed;
   logic       status;
   logic       next_status;
   logic       next_modulated_output;
   logic       next_slew_limit_enable;
   logic [8:0] next_source_pin_disable;

   // Picks a carrier source by selector code; reserved codes connect nothing.
   function automatic logic carrier_pick(input sgm_sel_t sel,
                                         input logic [`SGM_NUM_IN-1:0] s);
      logic v;
      v = 1'b0;
      case (sel)
         4'h1: v = s[1];
         4'h2: v = s[2];
         4'h3: v = s[3];
         4'h4: v = s[4];
         4'h5: v = s[5];
         4'h6: v = s[6];
         4'h7: v = s[7];
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   // Picks the modulator source; code zero is the software bit.
   function automatic logic mod_pick(input sgm_sel_t sel,
                                     input logic [`SGM_NUM_IN-1:0] s,
                                     input logic swbit);
      logic v;
      v = 1'b0;
      case (sel)
         4'h0: v = swbit;               // [RULE19]
         4'h1: v = s[`SGM_IN_MODPIN];   // [RULE20]
         4'h2: v = s[`SGM_IN_CCP];
         4'h3: v = s[`SGM_IN_CCP+1];
         4'h4: v = s[`SGM_IN_CCP+2];
         4'h5: v = s[`SGM_IN_CCP+3];
         4'h6: v = s[`SGM_IN_COMP];
         4'h7: v = s[`SGM_IN_COMP+1];
         4'h8: v = s[`SGM_IN_SER];
         4'h9: v = s[`SGM_IN_SER+1];
         4'hA: v = s[`SGM_IN_UART];
         default: v = 1'b0;             // [RULE21]
      endcase
      return v;
   endfunction

   // Maps a selector to the peripheral whose pin drive it removes.
   function automatic logic [8:0] pin_mask(input sgm_sel_t sel,
                                           input logic odis,
                                           input logic is_mod);
      logic [8:0] m;
      m = 9'h000;
      if (odis) begin
         if (is_mod) begin
            case (sel)
               4'h2: m = 9'h001;
               4'h3: m = 9'h002;
               4'h4: m = 9'h004;
               4'h5: m = 9'h008;
               4'h6: m = 9'h010;
               4'h7: m = 9'h020;
               4'h8: m = 9'h040;
               4'h9: m = 9'h080;
               4'hA: m = 9'h100;
               default: m = 9'h000;
            endcase
         end else begin
            case (sel)
               4'h4: m = 9'h001;
               4'h5: m = 9'h002;
               4'h6: m = 9'h004;
               4'h7: m = 9'h008;
               default: m = 9'h000;
            endcase
         end
      end
      return m;
   endfunction

   // Gathers all asynchronous sources into one vector.
   assign in_raw = {uart_tx_out, serial_data_out, comparator_out, capture_pwm_out,
                    ref_clock_signal, carrier_input_pin_b, carrier_input_pin_a,
                    modulator_input_pin};

   // Two-stage synchroniser per source input.
   for (genvar i = 0; i < `SGM_NUM_IN; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            in_meta[i] <= 1'b0;
            in_sync[i] <= 1'b0;
         end else begin
            in_meta[i] <= in_raw[i];
            in_sync[i] <= in_meta[i];
         end
      end
   end

   // Bus phase decode; a write lands at the access edge while pready is high.
   assign setup   = psel & ~penable;
   assign wr_fire = psel & penable & pready & pwrite;

   // Address decode and read mux; unimplemented bits read zero.
   always_comb begin
      mapped     = 1'b1;
      read_value = 8'h00;
      case (paddr)
         `SGM_ADDR_CTRL: begin
            read_value = modulation_control & `SGM_WMASK_CTRL;       // [RULE22]
            read_value[`SGM_BIT_STAT] = status;                     // [RULE18]
         end
         `SGM_ADDR_SRC:  read_value = modulation_source_select & `SGM_WMASK_SRC; // [RULE22]
         `SGM_ADDR_HIGH_CARRIER: read_value = high_carrier_control & `SGM_WMASK_CAR;
         `SGM_ADDR_LOW_CARRIER: read_value = low_carrier_control & `SGM_WMASK_CAR;
         default:        mapped = 1'b0;
      endcase
   end

   // Next register values from bus writes; only writable bits are stored.
   always_comb begin
      next_modulation_control       = modulation_control;
      next_modulation_source_select = modulation_source_select;
      next_high_carrier_control     = high_carrier_control;
      next_low_carrier_control      = low_carrier_control;
      if (wr_fire) begin
         case (paddr)
            `SGM_ADDR_CTRL: next_modulation_control = pwdata[7:0] & `SGM_WMASK_CTRL;
            `SGM_ADDR_SRC:  next_modulation_source_select = pwdata[7:0] & `SGM_WMASK_SRC;
            `SGM_ADDR_HIGH_CARRIER: next_high_carrier_control = pwdata[7:0] & `SGM_WMASK_CAR;
            `SGM_ADDR_LOW_CARRIER: next_low_carrier_control = pwdata[7:0] & `SGM_WMASK_CAR;
            default: next_modulation_control = modulation_control;
         endcase
      end
   end

   // Register file; reset leaves the module disabled with slew limiting on.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modulation_control       <= `SGM_RST_CTRL;   // [RULE15] [RULE13]
         modulation_source_select <= `SGM_RST_SRC;
         high_carrier_control     <= `SGM_RST_CAR;
         low_carrier_control      <= `SGM_RST_CAR;
      end else begin
         modulation_control       <= next_modulation_control;
         modulation_source_select <= next_modulation_source_select;
         high_carrier_control     <= next_high_carrier_control;
         low_carrier_control      <= next_low_carrier_control;
      end
   end

   // Bus answer: read data, error and ready are all captured in setup and appear together at the next edge.
   always_comb begin
      next_pready  = setup;
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (setup) begin
         next_prdata  = {24'h00_0000, read_value};
         next_pslverr = ~mapped;
      end
   end

   // Registers the bus answer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Source selection with polarity; a disabled module grounds both carriers.
   always_comb begin
      module_enable = modulation_control[`SGM_BIT_EN];
      high_carrier  = 1'b0;
      low_carrier   = 1'b0;
      mod_signal    = modulation_control[`SGM_BIT_SWBIT];          // [RULE3]
      if (module_enable) begin                                      // [RULE16]
         high_carrier = carrier_pick(high_carrier_control[3:0], in_sync)
                        ^ high_carrier_control[`SGM_BIT_POL];       // [RULE23] [RULE8]
         low_carrier  = carrier_pick(low_carrier_control[3:0], in_sync)
                        ^ low_carrier_control[`SGM_BIT_POL];        // [RULE9]
         mod_signal   = mod_pick(modulation_source_select[3:0], in_sync,
                                 modulation_control[`SGM_BIT_SWBIT]); // [RULE19]
      end
   end

   // Carrier switch: a synced carrier must be low before the switch is allowed.
   // Nothing here depends on a sleep state, so mixing goes on in sleep. [RULE14]
   always_comb begin
      next_state = state;
      case (state)
         SGM_ON_HIGH: begin
            if (!mod_signal &&
                !(high_carrier_control[`SGM_BIT_SYNC] && high_carrier)) begin // [RULE5] [RULE6]
               next_state = SGM_ON_LOW;
            end
         end
         SGM_ON_LOW: begin
            if (mod_signal &&
                !(low_carrier_control[`SGM_BIT_SYNC] && low_carrier)) begin   // [RULE5] [RULE7]
               next_state = SGM_ON_HIGH;
            end
         end
         default: next_state = SGM_ON_LOW;
      endcase
   end

   // Mixing: the active carrier passes ungated; only the state set by the modulator picks it.
   assign mixed = (state == SGM_ON_HIGH) ? (1'b1 & high_carrier)
                                         : (1'b1 & low_carrier);    // [RULE1] [RULE2]

   // Output stage next values: polarity, pin gating, slew and pin disables.
   always_comb begin
      next_status = mixed ^ modulation_control[`SGM_BIT_OINV];      // [RULE12] [RULE18]
      next_modulated_output = next_status & module_enable
                              & modulation_control[`SGM_BIT_OE];    // [RULE4] [RULE17]
      next_slew_limit_enable = modulation_control[`SGM_BIT_SLEW];   // [RULE13]
      next_source_pin_disable =
         pin_mask(high_carrier_control[3:0],
                  high_carrier_control[`SGM_BIT_ODIS], 1'b0)        // [RULE10]
       | pin_mask(low_carrier_control[3:0],
                  low_carrier_control[`SGM_BIT_ODIS], 1'b0)         // [RULE10]
       | pin_mask(modulation_source_select[3:0],
                  modulation_source_select[`SGM_BIT_ODIS], 1'b1);   // [RULE11]
   end

   // Registers the mixing state and all pin-facing outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state              <= SGM_ON_LOW;
         status             <= 1'b0;
         modulated_output   <= 1'b0;                                // [RULE15]
         slew_limit_enable  <= 1'b1;
         source_pin_disable <= 9'h000;
      end else begin
         state              <= next_state;
         status             <= next_status;
         modulated_output   <= next_modulated_output;
         slew_limit_enable  <= next_slew_limit_enable;
         source_pin_disable <= next_source_pin_disable;
      end
   end

endmodule

// >>> tb/sgm_modulator_asserts.sv
// Concurrent checks on the signal modulator's bus and pin ports.
// Assumes it is bound to sgm_modulator and sees only its ports.
`timescale 1ns/10ps
module sgm_modulator_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        modulated_output,
   input wire logic        slew_limit_enable,
   input wire logic [8:0]  source_pin_disable
);
   logic [7:0] ctl_sh;
   logic [7:0] src_sh;
   logic [7:0] next_ctl_sh;
   logic [7:0] next_src_sh;
   logic       wr;
   logic       map;
   // Shadow copies of control and source follow completed bus writes.
   always_comb begin
      wr = psel && penable && pready && pwrite;
      map = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
      next_ctl_sh = (wr && paddr == 12'h000) ? pwdata[7:0] : ctl_sh;
      next_src_sh = (wr && paddr == 12'h004) ? pwdata[7:0] : src_sh;
   end
   // Shadows reset to the register defaults.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_sh <= 8'h20;
         src_sh <= 8'h00;
      end else begin
         ctl_sh <= next_ctl_sh;
         src_sh <= next_src_sh;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
      else $error("pready missing after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access");
   unmapped_error_a: assert property (pready && !map |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mapped_clean_a: assert property (pready && map |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("mapped access wrong");
   reserved_zero_a: assert property (pready && !pwrite |->
      (paddr != 12'h000 || prdata[2:1] == 2'h0) && (paddr != 12'h004 || prdata[6:4] == 3'h0)
      && (paddr < 12'h008 || prdata[4] == 1'b0)) else $error("reserved bit not zero");
   slew_mirror_a: assert property ($stable(ctl_sh[5]) |-> slew_limit_enable == ctl_sh[5])
      else $error("slew output wrong");
   pin_low_a: assert property ((!ctl_sh[6]) [*4] |-> !modulated_output)
      else $error("pin driven while disabled");
   enable_off_a: assert property ((!ctl_sh[7]) [*6] |-> !modulated_output)
      else $error("output while module off");
   mod_pin_dis_a: assert property ($stable(src_sh) && src_sh[7] && src_sh[3:0] >= 4'h2
      && src_sh[3:0] <= 4'hA |-> source_pin_disable[src_sh[3:0] - 4'h2])
      else $error("modulator pin drive kept");
endmodule

// >>> tb/sgm_sources.sv
// Model of the peripherals and pins that feed the signal modulator.
// Assumes the bench sets static source levels; pin b runs as a free carrier.
`timescale 1ns/10ps
module sgm_sources (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [10:0] lvl,
   output logic            modulator_input_pin,
   output logic            carrier_input_pin_a,
   output logic            carrier_input_pin_b,
   output logic            ref_clock_signal,
   output logic [3:0]      capture_pwm_out,
   output logic [1:0]      comparator_out,
   output logic [1:0]      serial_data_out,
   output logic            uart_tx_out
);
   logic [5:0] cnt;
   logic [5:0] next_cnt;
   // Free running counter keeps pin b and the reference clock alive in every power mode.
   always_comb next_cnt = cnt + 6'h01;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 6'h00;
      end else begin
         cnt <= next_cnt;
      end
   end
   // Pin b has a 64-cycle period, half high.
   assign carrier_input_pin_b = cnt[5];
   assign ref_clock_signal = cnt[1];
   assign modulator_input_pin = lvl[0];
   assign capture_pwm_out = lvl[4:1];
   assign comparator_out = lvl[6:5];
   assign serial_data_out = lvl[8:7];
   assign uart_tx_out = lvl[9];
   assign carrier_input_pin_a = lvl[10];
endmodule

// >>> tb/test_sgm_modulator.sv
// Self-checking bench of the signal modulator over APB and its pins.
// Assumes the source model and the checker are compiled alongside.
`timescale 1ns/10ps
module test_sgm_modulator;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, modulated_output, slew_limit_enable;
   logic [8:0]  source_pin_disable;
   logic [10:0] lvl;
   logic        mpin, cpa, cpb, rclk, utx;
   logic [3:0]  pwm;
   logic [1:0]  cmp, ser;
   int          err_count, check_count;
   sgm_modulator u_sgm_modulator (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .modulator_input_pin(mpin),
      .carrier_input_pin_a(cpa), .carrier_input_pin_b(cpb), .ref_clock_signal(rclk),
      .capture_pwm_out(pwm), .comparator_out(cmp), .serial_data_out(ser), .uart_tx_out(utx),
      .modulated_output(modulated_output), .slew_limit_enable(slew_limit_enable),
      .source_pin_disable(source_pin_disable));
   sgm_sources u_sgm_sources (.pclk(pclk), .presetn(presetn), .lvl(lvl),
      .modulator_input_pin(mpin), .carrier_input_pin_a(cpa), .carrier_input_pin_b(cpb),
      .ref_clock_signal(rclk), .capture_pwm_out(pwm), .comparator_out(cmp),
      .serial_data_out(ser), .uart_tx_out(utx));
   // Compares one value and counts it.
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; the request holds until pready is sampled high.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
            output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        er;
      apb(1'b1, a, {24'h0, d}, r, er);
   endtask
   // Reads a word and checks data and the error flag.
   task rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic        er;
      apb(1'b0, a, 32'h0, r, er);
      chk("rdata", r, e);
      chk("rerr", 32'(er), 32'(a > 12'h00C));
   endtask
   task t_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("out", 32'(modulated_output), 32'h0);
      chk("slew", 32'(slew_limit_enable), 32'h1);
      rdc(12'h000, 32'h20);
      rdc(12'h004, 32'h00);
      rdc(12'h008, 32'h00);
      rdc(12'h00C, 32'h00);
      rdc(12'h010, 32'h00);
      $display("test reset done");
   endtask
   task t_regs;
      wr(12'h000, 8'h51);
      // The slew pin is registered one edge after the control write lands.
      repeat (2) @(posedge pclk);
      chk("slew", 32'(slew_limit_enable), 32'h0);
      rdc(12'h000, 32'h59);
      wr(12'h004, 8'hFF);
      rdc(12'h004, 32'h8F);
      wr(12'h008, 8'hFF);
      wr(12'h00C, 8'hFF);
      wr(12'h010, 8'hFF);
      rdc(12'h008, 32'hEF);
      rdc(12'h00C, 32'hEF);
      wr(12'h000, 8'h20);
      $display("test regs done");
   endtask
   task t_mix;
      logic [4:0] v;
      logic       e;
      for (int i = 0; i < 32; i++) begin
         v = 5'(i);
         e = (v[0] ? v[1] ^ v[2] : v[3]) ^ v[4];
         wr(12'h008, {1'b0, v[2], 6'h01});
         wr(12'h00C, {1'b0, v[3], 6'h00});
         wr(12'h004, 8'h00);
         wr(12'h000, {3'h6, v[4], 3'h0, v[0]});
         lvl[10] <= v[1];
         repeat (8) @(posedge pclk);
         chk("out", 32'(modulated_output), 32'(e));
         rdc(12'h000, {24'h0, 3'h6, v[4], e, 2'h0, v[0]});
      end
      $display("test mix done");
   endtask
   task t_modsel;
      logic [9:0] oh;
      wr(12'h008, 8'h01);
      wr(12'h00C, 8'h00);
      wr(12'h000, 8'hC1);
      for (int c = 0; c < 16; c++) begin
         for (int p = 0; p < 2; p++) begin
            oh = (c >= 1 && c <= 10) ? 10'(1 << (c - 1)) : 10'h0;
            wr(12'h004, {4'h8, 4'(c)});
            lvl <= {1'b1, (p == 1) ? oh : ~oh};
            repeat (8) @(posedge pclk);
            chk("out", 32'(modulated_output), 32'(c == 0 || (p == 1 && c <= 10)));
            chk("pdis", 32'(source_pin_disable), (c >= 2 && c <= 10) ? 32'(1 << (c - 2)) : 32'h0);
         end
      end
      for (int k = 4; k < 8; k++) begin
         wr(k[0] ? 12'h00C : 12'h008, {4'h8, 4'(k)});
         repeat (2) @(posedge pclk);
         chk("pdis", 32'(source_pin_disable), 32'(1 << (k - 4)));
         wr(k[0] ? 12'h00C : 12'h008, k[0] ? 8'h00 : 8'h01);
      end
      $display("test modsel done");
   endtask
   task t_disable;
      wr(12'h004, 8'h80);
      lvl <= 11'h400;
      wr(12'h000, 8'hA1);
      repeat (8) @(posedge pclk);
      chk("out", 32'(modulated_output), 32'h0);
      rdc(12'h000, 32'hA9);
      wr(12'h000, 8'h51);
      repeat (8) @(posedge pclk);
      chk("out", 32'(modulated_output), 32'h0);
      rdc(12'h004, 32'h80);
      wr(12'h000, 8'hC1);
      repeat (8) @(posedge pclk);
      chk("out", 32'(modulated_output), 32'h1);
      $display("test disable done");
   endtask
   // Leaves the pin b carrier mid-pulse, with sync on it or on the other carrier.
   task t_sync(input logic h, input logic s);
      wr(h ? 12'h008 : 12'h00C, {2'h0, s, 5'h02});
      wr(h ? 12'h00C : 12'h008, {2'h0, !s, 5'h00});
      wr(12'h004, 8'h00);
      wr(12'h000, {7'h60, h});
      while (cpb !== 1'b0) @(posedge pclk);
      while (cpb !== 1'b1) @(posedge pclk);
      repeat (6) @(posedge pclk);
      chk("out", 32'(modulated_output), 32'h1);
      wr(12'h000, {7'h60, !h});
      repeat (6) @(posedge pclk);
      chk("out", 32'(modulated_output), 32'(s));
      repeat (40) @(posedge pclk);
      chk("out", 32'(modulated_output), 32'h0);
      $display("test sync done");
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      #200000;
      err_count++;
      test_done;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
      err_count = 0;
      check_count = 0;
      t_reset;
      t_regs;
      t_mix;
      t_modsel;
      t_disable;
      for (int m = 0; m < 4; m++) t_sync(m[0], m[1]);
      t_reset;
      test_done;
   end
endmodule
bind sgm_modulator sgm_modulator_asserts u_sgm_modulator_asserts (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .modulated_output(modulated_output), .slew_limit_enable(slew_limit_enable),
   .source_pin_disable(source_pin_disable));
